// >>> hdl/ppic_capture.sv
/*
  pixel port input capture: samples the 6:6:6 pixel stream and qualifiers,
  passes panel power requests through under external sequencing.
  assumes pixel_clock_in runs continuously after reset; pixel inputs are
  synchronous to it, power requests are asynchronous.
  assumes reset_in is synchronous to pixel_clock_in and active high.
*/
`timescale 1ns/1ps
`include "ppic_consts.svh"

module ppic_capture
  import ppic_pkg::*;
(
  // clock and reset
  input  wire logic       pixel_clock_in,
  input  wire logic       reset_in,
  // pixel port
  input  wire ppic_chan_t red_in,
  input  wire ppic_chan_t green_in,
  input  wire ppic_chan_t blue_in,
  input  wire logic       active_display_enable_in,
  input  wire logic       line_blank_sync_in,
  input  wire logic       frame_blank_sync_in,
  // panel power
  input  wire logic       power_seq_external_in,
  input  wire logic       panel_vdd_request_in,
  input  wire logic       panel_contrast_request_in,
  output logic            panel_vdd_enable_out,
  output logic            panel_contrast_enable_out,
  // downstream pixel stream
  output ppic_word_t      pixel_word_out,
  output logic            pixel_valid_out,
  output logic            line_start_out,
  output logic            frame_start_out
);

  // ****************************************
  // pixel port sampling
  // ****************************************
  // pixel inputs share the pixel clock, so no synchroniser here
  ppic_word_t word_r, word_nxt;
  logic       valid_r, valid_nxt;
  logic       hs_r, hs_nxt, vs_r, vs_nxt;
  logic       ls_r, ls_nxt, fs_r, fs_nxt;

  // a blanking sync has ended when it was high last edge and is low now
  function automatic logic sync_end(input logic was_high, input logic now_high);
    sync_end = was_high & ~now_high;
  endfunction : sync_end

  always_comb begin
    word_nxt[`PPIC_RED_HI:`PPIC_RED_LO] = red_in;
    word_nxt[`PPIC_GRN_HI:`PPIC_GRN_LO] = green_in;
    word_nxt[`PPIC_BLU_HI:`PPIC_BLU_LO] = blue_in;
    valid_nxt = active_display_enable_in & ~line_blank_sync_in
                & ~frame_blank_sync_in;
    hs_nxt    = line_blank_sync_in;
    vs_nxt    = frame_blank_sync_in;
    ls_nxt    = sync_end(hs_r, line_blank_sync_in);
    fs_nxt    = sync_end(vs_r, frame_blank_sync_in);
  end

  always_ff @(posedge pixel_clock_in) begin
    if (reset_in) begin
      word_r  <= `PPIC_LOW_18;
      valid_r <= `PPIC_LOW_1;
      hs_r    <= `PPIC_LOW_1;
      vs_r    <= `PPIC_LOW_1;
      ls_r    <= `PPIC_LOW_1;
      fs_r    <= `PPIC_LOW_1;
    end else begin
      word_r  <= word_nxt;
      valid_r <= valid_nxt;
      hs_r    <= hs_nxt;
      vs_r    <= vs_nxt;
      ls_r    <= ls_nxt;
      fs_r    <= fs_nxt;
    end
  end

  assign pixel_word_out  = word_r;
  assign pixel_valid_out = valid_r;
  assign line_start_out  = ls_r;
  assign frame_start_out = fs_r;

  // ****************************************
  // panel power pass-through
  // ****************************************
  // two stages per asynchronous level; stage one feeds stage two only
  logic [`PPIC_PWR_N-1:0] pwr_async;
  logic [`PPIC_PWR_N-1:0] pwr_sync;
  logic                   vdd_en_r, vdd_en_nxt, con_en_r, con_en_nxt;

  assign pwr_async[`PPIC_PWR_VDD] = panel_vdd_request_in;
  assign pwr_async[`PPIC_PWR_CON] = panel_contrast_request_in;
  assign pwr_async[`PPIC_PWR_SEL] = power_seq_external_in;

  for (genvar k = 0; k < `PPIC_PWR_N; k++) begin : g_sync
    logic [`PPIC_SYNC_N-1:0] stage_r, stage_nxt;

    always_comb begin
      stage_nxt = {stage_r[`PPIC_SYN_IN], pwr_async[k]};
    end

    always_ff @(posedge pixel_clock_in) begin
      if (reset_in) begin
        stage_r <= `PPIC_LOW_2;
      end else begin
        stage_r <= stage_nxt;
      end
    end

    assign pwr_sync[k] = stage_r[`PPIC_SYN_OUT];
  end

  // sequencing is picked by a pin, since this block has no registers
  function automatic logic ext_gate(input logic sel_ext, input logic req);
    ext_gate = (sel_ext == `PPIC_SEQ_EXT) & req;
  endfunction : ext_gate

  always_comb begin
    // internal sequencing is outside this block, so the enables hold low
    vdd_en_nxt = ext_gate(pwr_sync[`PPIC_PWR_SEL], pwr_sync[`PPIC_PWR_VDD]);
    con_en_nxt = ext_gate(pwr_sync[`PPIC_PWR_SEL], pwr_sync[`PPIC_PWR_CON]);
  end

  always_ff @(posedge pixel_clock_in) begin
    if (reset_in) begin
      vdd_en_r <= `PPIC_LOW_1;
      con_en_r <= `PPIC_LOW_1;
    end else begin
      vdd_en_r <= vdd_en_nxt;
      con_en_r <= con_en_nxt;
    end
  end

  assign panel_vdd_enable_out      = vdd_en_r;
  assign panel_contrast_enable_out = con_en_r;

  // ****************************************
  // checks
  // ****************************************
  a_red_map: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    !$past(reset_in) |-> pixel_word_out[`PPIC_RED_HI:`PPIC_RED_LO] == $past(red_in))
    else $error("red bits misplaced");
  a_green_map: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    !$past(reset_in) |-> pixel_word_out[`PPIC_GRN_HI:`PPIC_GRN_LO] == $past(green_in))
    else $error("green bits misplaced");
  a_blue_map: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    !$past(reset_in) |-> pixel_word_out[`PPIC_BLU_HI:`PPIC_BLU_LO] == $past(blue_in))
    else $error("blue bits misplaced");
  a_valid_gate: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    active_display_enable_in && !line_blank_sync_in && !frame_blank_sync_in
    |=> pixel_valid_out)
    else $error("qualified pixel dropped");
  a_line_blank: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    line_blank_sync_in |=> !pixel_valid_out)
    else $error("pixel passed in line blank");
  a_frame_blank: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    frame_blank_sync_in |=> !pixel_valid_out)
    else $error("pixel passed in frame blank");
  a_vdd_follow: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (power_seq_external_in && panel_vdd_request_in)[*4] |-> panel_vdd_enable_out)
    else $error("vdd enable not following request");
  a_con_follow: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (power_seq_external_in && panel_contrast_request_in)[*4] |-> panel_contrast_enable_out)
    else $error("contrast enable not following request");
  a_vdd_sync: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    $rose(panel_vdd_enable_out) |-> $past(panel_vdd_request_in, 3))
    else $error("vdd enable rose without synchronised request");
  a_valid_source: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    pixel_valid_out |-> $past(active_display_enable_in) && !$past(line_blank_sync_in)
      && !$past(frame_blank_sync_in))
    else $error("pixel passed without qualification");
  a_line_start: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    !$past(reset_in) && $fell(line_blank_sync_in) |=> line_start_out)
    else $error("line start pulse missing");
  a_frame_start: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    !$past(reset_in) && $fell(frame_blank_sync_in) |=> frame_start_out)
    else $error("frame start pulse missing");
  a_line_pulse: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    line_start_out |-> $past(line_blank_sync_in, 2) && !$past(line_blank_sync_in))
    else $error("line start pulse without sync end");
  a_frame_pulse: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    frame_start_out |-> $past(frame_blank_sync_in, 2) && !$past(frame_blank_sync_in))
    else $error("frame start pulse without sync end");

  // ****************************************
  // power checks
  // ****************************************
  a_con_sync: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    $rose(panel_contrast_enable_out) |-> $past(panel_contrast_request_in, 3))
    else $error("contrast enable rose without synchronised request");
  a_vdd_select: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    $rose(panel_vdd_enable_out) |-> $past(power_seq_external_in, 3))
    else $error("vdd enable rose without external sequencing");
  a_con_select: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    $rose(panel_contrast_enable_out) |-> $past(power_seq_external_in, 3))
    else $error("contrast enable rose without external sequencing");
  a_vdd_internal: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (!power_seq_external_in)[*4] |-> !panel_vdd_enable_out)
    else $error("vdd enable high under internal sequencing");
  a_con_internal: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (!power_seq_external_in)[*4] |-> !panel_contrast_enable_out)
    else $error("contrast enable high under internal sequencing");
  a_vdd_release: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (!panel_vdd_request_in)[*4] |-> !panel_vdd_enable_out)
    else $error("vdd enable stayed high after request fell");
  a_con_release: assert property (@(posedge pixel_clock_in) disable iff (reset_in)
    (!panel_contrast_request_in)[*4] |-> !panel_contrast_enable_out)
    else $error("contrast enable stayed high after request fell");

endmodule : ppic_capture

// >>> inc/ppic_consts.svh
/*
  constants for the pixel port input capture block.
  assumes inclusion by bare name from the package or design files.
*/
`ifndef PPIC_CONSTS_SVH
`define PPIC_CONSTS_SVH

`define PPIC_CHAN_W   6
`define PPIC_WORD_W   18
`define PPIC_RED_HI   17
`define PPIC_RED_LO   12
`define PPIC_GRN_HI   11
`define PPIC_GRN_LO   6
`define PPIC_BLU_HI   5
`define PPIC_BLU_LO   0
`define PPIC_LOW_1    1'h0
`define PPIC_LOW_6    6'h00
`define PPIC_LOW_18   18'h00000
`define PPIC_SEQ_EXT  1'h1
`define PPIC_LOW_2    2'h0
`define PPIC_SYNC_N   2
`define PPIC_SYN_IN   0
`define PPIC_SYN_OUT  1
`define PPIC_PWR_N    3
`define PPIC_PWR_VDD  0
`define PPIC_PWR_CON  1
`define PPIC_PWR_SEL  2

`endif

// >>> inc/ppic_pkg.sv
/*
  types for the pixel port input capture block.
  assumes the constants header is on the include path.
*/
`include "ppic_consts.svh"

package ppic_pkg;
  typedef logic [`PPIC_CHAN_W-1:0] ppic_chan_t;
  typedef logic [`PPIC_WORD_W-1:0] ppic_word_t;
endpackage : ppic_pkg

// >>> test/ppic_video_src.sv
/* video source model: random 6:6:6 pixels with line and frame blanking.
   assumes the bench makes the clock and may ask for rogue enables. */
`timescale 1ns/1ps
module ppic_video_src import ppic_pkg::*; (
  input  wire logic  clk_in,
  input  wire logic  rogue_in,
  output ppic_chan_t red_out,
  output ppic_chan_t green_out,
  output ppic_chan_t blue_out,
  output logic       enable_out,
  output logic       line_sync_out,
  output logic       frame_sync_out
);
  int cnt = 0;
  initial {red_out, green_out, blue_out, enable_out, line_sync_out, frame_sync_out} = '0;
  always @(posedge clk_in) begin
    #1;
    cnt++;
    {red_out, green_out, blue_out} = 18'($urandom);
    line_sync_out = (cnt % 8) > 5;
    frame_sync_out = (cnt % 96) > 85;
    // rogue mode overlaps enable with blanking to prove the gating
    enable_out = rogue_in ? 1'($urandom) : !line_sync_out && !frame_sync_out && 1'($urandom);
  end
endmodule : ppic_video_src

// >>> test/testbench.sv
/* bench for the pixel capture block: integer model checked every edge outside reset except the first four after each reset.
   assumes the video source model drives the pixel port. */
`timescale 1ns/1ps
module testbench import ppic_pkg::*; ;
  logic       clk_in = 1'h0;
  logic       reset_in = 1'h1;
  logic       sel = 1'h0, vreq = 1'h0, creq = 1'h0, rogue = 1'h0;
  logic [3:0] hv = 4'h0, hc = 4'h0;
  ppic_chan_t r, g, b;
  ppic_word_t word;
  logic       en, hs, vs, vdd, con, val, ls, fs;
  int mismatches = 0, n_tests = 0, age = 0, rp = 1, lhs = 0, lfs = 0;
  int e_w = 0, e_v = 0, e_l = 0, e_f = 0;
  always #10 clk_in = ~clk_in;
  ppic_video_src src (.clk_in(clk_in), .rogue_in(rogue), .red_out(r), .green_out(g),
    .blue_out(b), .enable_out(en), .line_sync_out(hs), .frame_sync_out(vs));
  ppic_capture uut (.pixel_clock_in(clk_in), .reset_in(reset_in), .red_in(r),
    .green_in(g), .blue_in(b), .active_display_enable_in(en), .line_blank_sync_in(hs),
    .frame_blank_sync_in(vs), .power_seq_external_in(sel), .panel_vdd_request_in(vreq),
    .panel_contrast_request_in(creq), .panel_vdd_enable_out(vdd),
    .panel_contrast_enable_out(con), .pixel_word_out(word), .pixel_valid_out(val),
    .line_start_out(ls), .frame_start_out(fs));
  task automatic check(input string nm, input logic [17:0] got, input int exp);
    n_tests++;
    if (got !== 18'(exp)) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'hB13A));
    for (int i = 0; i < 1600; i++) begin
      @(posedge clk_in);
      #1;
      // second reset lands mid-frame while rogue enables run
      reset_in = i < 16 || (i >= 800 && i < 803);
      rogue = i >= 400 && i < 1200;
      if ($urandom % 4 == 0) {sel, vreq, creq} = 3'($urandom);
      hv = {hv[2:0], sel & vreq};
      hc = {hc[2:0], sel & creq};
      #1;
      if (rp) begin
        age = 0;
        check("word in reset", word, 0);
        check("flags in reset", {vdd, con, val, ls, fs}, 0);
      end else if (++age > 4) begin
        check("pixel word", word, e_w);
        check("pixel valid", val, e_v);
        check("line start", ls, e_l);
        check("frame start", fs, e_f);
        check("vdd enable", vdd, hv[3]);
        check("contrast enable", con, hc[3]);
      end
      rp = reset_in;
      e_w = {r, g, b};
      e_v = en && !hs && !vs;
      e_l = lhs && !hs;
      e_f = lfs && !vs;
      lhs = hs;
      lfs = vs;
    end
    wrap_up();
  end
endmodule : testbench
